// *** rps_pkg.sv ***
// Constants, types and register map of the remappable pin select block.
// Assumes an Avalon-MM master with 32-bit data and byte addresses.
package rps_pkg;

  // ===========================================================
  // Sizes
  localparam int unsigned RPS_SEL_W    = 6;
  localparam int unsigned RPS_NUM_PINS = 64;
  localparam int unsigned RPS_NUM_FUNC = 64;
  localparam int unsigned RPS_NUM_FLD  = 16;
  localparam int unsigned RPS_NUM_IN   = 13;
  localparam int unsigned RPS_ADDR_W   = 6;

  // ===========================================================
  // Register byte offsets
  localparam logic [5:0] RPS_OFF_UART3_CTS_AND_SPI1_SELECT_INPUT_MAP = 6'h00;
  localparam logic [5:0] RPS_OFF_SPI2_CLOCK_AND_DATA_INPUT_MAP       = 6'h04;
  localparam logic [5:0] RPS_OFF_TIMER_CLOCK_AND_SPI2_SELECT_INPUT_MAP = 6'h08;
  localparam logic [5:0] RPS_OFF_LOGIC_CELL_INPUTS_MAP               = 6'h0C;
  localparam logic [5:0] RPS_OFF_UART4_INPUTS_MAP                    = 6'h10;
  localparam logic [5:0] RPS_OFF_SPI3_CLOCK_AND_DATA_INPUT_MAP       = 6'h14;
  localparam logic [5:0] RPS_OFF_SPI3_SELECT_INPUT_MAP               = 6'h18;
  localparam logic [5:0] RPS_OFF_PINS_ZERO_ONE_OUTPUT_MAP            = 6'h1C;
  localparam logic [5:0] RPS_OFF_LAST                                = 6'h1C;

  // ===========================================================
  // Field layout: field index is register index times two plus one
  // for the upper selector.
  localparam int unsigned RPS_HI_LSB      = 8;
  localparam int unsigned RPS_LO_LSB      = 0;
  localparam int unsigned RPS_FLD_NONE    = 13;
  localparam int unsigned RPS_FLD_OUT0    = 14;
  localparam int unsigned RPS_FLD_OUT1    = 15;
  localparam logic [5:0]  RPS_IN_SEL_RST  = 6'h3F;
  localparam logic [5:0]  RPS_OUT_SEL_RST = 6'h00;

  // Field that steers each routed peripheral input, in struct order.
  localparam int unsigned RPS_IN_FIELD [RPS_NUM_IN] =
    '{1, 0, 3, 2, 5, 4, 7, 6, 9, 8, 11, 10, 12};

  // ===========================================================
  // Bus answer codes
  localparam logic [1:0] RPS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RPS_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic uart3_cts;
    logic spi1_slave_select_in;
    logic spi2_clock_in;
    logic spi2_data_in;
    logic timer_external_clock;
    logic spi2_slave_select_in;
    logic logic_external_input_b;
    logic logic_external_input_a;
    logic uart4_cts;
    logic uart4_receive;
    logic spi3_clock_in;
    logic spi3_data_in;
    logic spi3_slave_select_in;
  } rps_periph_in_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } rps_avm_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
    logic [1:0]  response;
  } rps_avm_rsp_t;

endpackage

// *** rps_remappable_pin_select.sv ***
// Remappable pin select: selector registers, input routing from pins to
// peripherals and output routing from peripheral functions to pins 0, 1.
// Assumes pins arrive asynchronously and function outputs share clk_i.
module rps_remappable_pin_select (
  // Clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               reset_n_i,
  // Avalon-MM slave
  input  wire rps_pkg::rps_avm_req_t              avm_req_i,
  output rps_pkg::rps_avm_rsp_t                   avm_rsp_o,
  // Remappable pins
  input  wire logic [rps_pkg::RPS_NUM_PINS-1:0]   remappable_pin_i,
  output logic [1:0]                              remappable_pin_o,
  output logic [1:0]                              remappable_pin_mapped_o,
  // Peripheral side
  input  wire logic [rps_pkg::RPS_NUM_FUNC-1:0]   periph_func_i,
  output rps_pkg::rps_periph_in_t                 periph_in_o
);
  import rps_pkg::*;

  // ===========================================================
  // Bus slave
  logic                  wait_q;
  logic [31:0]           rd_word;
  logic [1:0]            rd_resp;
  logic                  req_seen;
  logic                  hit;
  logic [2:0]            reg_idx;
  logic [RPS_SEL_W-1:0]  field_q [RPS_NUM_FLD];
  logic                  wr_take;

  assign req_seen = (avm_req_i.read || avm_req_i.write) && wait_q;
  assign hit      = (avm_req_i.address <= RPS_OFF_LAST) &&
                    (avm_req_i.address[1:0] == 2'h0);
  assign reg_idx  = avm_req_i.address[4:2];
  assign wr_take  = avm_req_i.write && !wait_q && hit;

  // Waitrequest drops for one cycle in the cycle after a request shows.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wait_q <= 1'b1;
    end else if (req_seen) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read word of the addressed register; unmapped reads give zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = RPS_RESP_DECERR;
    if (hit) begin
      rd_word = {16'h0000,
                 2'b00, field_q[{reg_idx, 1'b1}],
                 2'b00, field_q[{reg_idx, 1'b0}]};
      rd_resp = RPS_RESP_OKAY;
    end
  end

  // Read data is loaded together with the drop of waitrequest, so it
  // stands in the very cycle in which the master takes it.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      avm_rsp_o <= '{waitrequest: 1'b1,
                     readdata:    32'h0000_0000,
                     response:    RPS_RESP_OKAY};
    end else begin
      avm_rsp_o.waitrequest <= !req_seen;
      if (req_seen) begin
        avm_rsp_o.readdata <= rd_word;
        avm_rsp_o.response <= rd_resp;
      end
    end
  end

  // ===========================================================
  // Selector fields
  for (genvar f = 0; f < RPS_NUM_FLD; f++) begin : g_field
    localparam logic [2:0] REG_IDX = 3'(f / 2);
    localparam bit         IS_HI   = (f % 2) == 1;
    localparam bit         IS_OUT  = f >= RPS_FLD_OUT0;
    localparam bit         STORED  = f != RPS_FLD_NONE;
    localparam logic [RPS_SEL_W-1:0] RST =
      (IS_OUT || !STORED) ? RPS_OUT_SEL_RST : RPS_IN_SEL_RST;
    logic lane_en;
    logic [RPS_SEL_W-1:0] wr_val;

    assign lane_en = IS_HI ? avm_req_i.byteenable[1]
                           : avm_req_i.byteenable[0];
    assign wr_val  = IS_HI
      ? avm_req_i.writedata[RPS_HI_LSB +: RPS_SEL_W]
      : avm_req_i.writedata[RPS_LO_LSB +: RPS_SEL_W];

    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        field_q[f] <= RST;
      end else if (STORED && wr_take && lane_en &&
                   reg_idx == REG_IDX) begin
        field_q[f] <= wr_val;
      end
    end
  end

  // ===========================================================
  // Pin synchroniser
  logic [RPS_NUM_PINS-1:0] pin_meta_q;
  logic [RPS_NUM_PINS-1:0] pin_sync_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= remappable_pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ===========================================================
  // Input routing
  logic [RPS_NUM_IN-1:0] routed;

  for (genvar i = 0; i < RPS_NUM_IN; i++) begin : g_in_route
    assign routed[RPS_NUM_IN-1-i] =
      pin_sync_q[field_q[RPS_IN_FIELD[i]]];
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      periph_in_o <= '0;
    end else begin
      periph_in_o <= rps_periph_in_t'(routed);
    end
  end

  // ===========================================================
  // Output routing
  for (genvar p = 0; p < 2; p++) begin : g_out_route
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        remappable_pin_o[p]        <= 1'b0;
        remappable_pin_mapped_o[p] <= 1'b0;
      end else begin
        remappable_pin_o[p] <=
          periph_func_i[field_q[RPS_FLD_OUT0 + p]];
        remappable_pin_mapped_o[p] <=
          field_q[RPS_FLD_OUT0 + p] != RPS_OUT_SEL_RST;
      end
    end
  end

endmodule

// *** rps_far_model.sv ***
// Far side of the pin select block: remappable pins and functions.
// Assumes the bench names the one pin and one function held high.
module rps_far_model (
  // Clock and choice of the high line
  input  wire logic       clk_i,
  input  wire logic [5:0] hot_pin_i,
  input  wire logic [5:0] hot_func_i,
  // Driven lines
  output logic [63:0]     remappable_pin_o,
  output logic [63:0]     periph_func_o
);
  // One line high and the rest low, so a wrong route reads as zero.
  always @(posedge clk_i) begin
    remappable_pin_o <= 64'h1 << hot_pin_i;
    periph_func_o    <= 64'h1 << hot_func_i;
  end
endmodule

// *** rps_remappable_pin_select_properties.sv ***
// Checker of the pin select block's bus answers and output routing.
// Assumes the bind below, on the block's own ports.
module rps_sel_chk (
  input wire logic                  clk_i,
  input wire logic                  reset_n_i,
  input wire rps_pkg::rps_avm_req_t avm_req_i,
  input wire rps_pkg::rps_avm_rsp_t avm_rsp_o,
  input wire logic [1:0]            remappable_pin_o,
  input wire logic [1:0]            remappable_pin_mapped_o,
  input wire logic [63:0]           periph_func_i
);
  import rps_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic rq;
  logic wt;
  logic rd;
  assign rq = avm_req_i.read || avm_req_i.write;
  assign wt = avm_rsp_o.waitrequest;
  assign rd = avm_req_i.read && !wt;
  // ====
  // Properties
  property p_one_wait; rq && wt |=> !wt; endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer");
  property p_short; !wt |=> wt; endproperty
  a_short: assert property (p_short) else $error("long answer");
  property p_cause; $fell(wt) |-> $past(rq); endproperty
  a_cause: assert property (p_cause) else $error("stray answer");
  property p_zero; rd |-> avm_rsp_o.readdata[31:14] == 0
    && avm_rsp_o.readdata[7:6] == 0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_last; rd && avm_req_i.address == 6'h18
    |-> avm_rsp_o.readdata[13:8] == 0; endproperty
  a_last: assert property (p_last) else $error("bad last map");
  property p_out0; $past(reset_n_i) && !remappable_pin_mapped_o[0]
    |-> remappable_pin_o[0] == $past(periph_func_i[0]); endproperty
  a_out0: assert property (p_out0) else $error("pin 0 route");
  property p_out1; $past(reset_n_i) && !remappable_pin_mapped_o[1]
    |-> remappable_pin_o[1] == $past(periph_func_i[0]); endproperty
  a_out1: assert property (p_out1) else $error("pin 1 route");
  property p_map0; avm_req_i.write && !wt && avm_req_i.address == 6'h1C
    && avm_req_i.byteenable[0] |-> ##2 remappable_pin_mapped_o[0]
    == ($past(avm_req_i.writedata[5:0], 2) != 0); endproperty
  a_map0: assert property (p_map0) else $error("late map");
  c_read: cover property (rd);
  c_write: cover property (avm_req_i.write && !wt);
  c_map: cover property (remappable_pin_mapped_o == 2'h3);
endmodule
bind rps_remappable_pin_select rps_sel_chk u_chk (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .avm_req_i(avm_req_i), .avm_rsp_o(avm_rsp_o),
  .remappable_pin_o(remappable_pin_o),
  .remappable_pin_mapped_o(remappable_pin_mapped_o),
  .periph_func_i(periph_func_i));

// *** rps_remappable_pin_select_tb.sv ***
// Self-checking bench of the remappable pin select block.
// Assumes the far-side model and the checker are compiled first.
module rps_remappable_pin_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rps_pkg::*;
  logic           clk_i = 1'b0;
  logic           reset_n_i = 1'b0;
  rps_avm_req_t   req = '0;
  rps_avm_rsp_t   rsp;
  logic [63:0]    pins;
  logic [63:0]    funcs;
  logic [5:0]     hot_pin = 6'h00;
  logic [5:0]     hot_func = 6'h00;
  logic [1:0]     pin_o;
  logic [1:0]     mapped_o;
  rps_periph_in_t pin_in;
  logic [31:0]    rdat;
  logic [1:0]     resp;
  int             mismatches = 0;
  int             comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  rps_far_model FAR (.clk_i(clk_i), .hot_pin_i(hot_pin),
    .hot_func_i(hot_func), .remappable_pin_o(pins), .periph_func_o(funcs));
  rps_remappable_pin_select DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avm_req_i(req), .avm_rsp_o(rsp), .remappable_pin_i(pins),
    .remappable_pin_o(pin_o), .remappable_pin_mapped_o(mapped_o),
    .periph_func_i(funcs), .periph_in_o(pin_in));
  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One whole access, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{!wr, wr, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    rdat = rsp.readdata;
    resp = rsp.response;
    req <= '0;
    if (n >= 20) begin
      check("bus answer", 32'h0, 32'h1);
      test_done();
    end
  endtask
  task automatic t_reset_values();
    for (int r = 0; r < 8; r++) begin
      bus(0, 6'(4 * r), 32'h0);
      check("reset", r == 7 ? 32'h0 : r == 6 ? 32'h3F : 32'h3F3F, rdat);
    end
  endtask
  task automatic t_unused_bits();
    for (int r = 0; r < 8; r++) begin
      bus(1, 6'(4 * r), 32'hFFFFFFFF);
      bus(0, 6'(4 * r), 32'h0);
      check("ones", r == 6 ? 32'h3F : 32'h3F3F, rdat);
    end
    bus(1, 6'h20, 32'hFFFFFFFF);
    bus(0, 6'h20, 32'h0);
    check("unmapped", 32'h3, 32'(resp) | rdat);
  endtask
  task automatic t_in_route();
    for (int r = 0; r < 7; r++)
      bus(1, 6'(4 * r), 32'((2 * r + 41) << 8 | (2 * r + 40)));
    for (int j = 0; j < 13; j++) begin
      @(posedge clk_i);
      hot_pin <= 6'(RPS_IN_FIELD[j] + 40);
      repeat (6) @(posedge clk_i);
      check("routed in", 32'h1 << (12 - j), 32'(pin_in));
    end
  endtask
  task automatic t_out_route();
    bus(1, 6'h1C, 32'h3F05);
    for (int i = 0; i < 3; i++) begin
      if (i == 2)
        bus(1, 6'h1C, 32'h0);
      @(posedge clk_i);
      hot_func <= i == 0 ? 6'h05 : i == 1 ? 6'h3F : 6'h00;
      repeat (4) @(posedge clk_i);
      check("pin out", 32'(i + 1), 32'(pin_o));
      check("mapped", i == 2 ? 32'h0 : 32'h3, 32'(mapped_o));
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset_values();
    t_unused_bits();
    t_in_route();
    t_out_route();
    test_done();
  end
endmodule
